// File: src/pwm_mode_dead_time.sv
// pwm channel: mode select, counter, capture and automatic dead time
// How it works
// RULE1: software changes mode only while stopped
// RULE2: capture decodes only the top mode bit
// RULE3: capture counts saw if top 0, triangle if 1
// RULE4: event sources set means mode stays 000b
// RULE5: negative dead time from up dead-time register
// RULE6: software must not write compare b
// RULE7: computed dead-time compare readable in compare b
// RULE8: software keeps dead time within period
// RULE9: dead-time error adjusts both compare points
// RULE10: adjusted negative value written into compare b
// RULE11: adjusted positive value internal, compare a untouched
// RULE12: one-shot settings must keep change-point order
// RULE13: recompute loads compare b next count clock
// RULE14: triangle also loads after the crest
`timescale 1ns/100ps
module pwm_mode_dead_time
  import pwm_dt_pkg::*;
#(
  parameter int unsigned SRC_W = 4
) (
  // apb clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // event source and capture pins
  input  wire logic [SRC_W-1:0]  event_src,
  input  wire logic              capture_pin,
  // waveform outputs and interrupt
  output logic                   pos_out,
  output logic                   neg_out,
  output logic                   irq
);
  if (SRC_W < 1 || SRC_W > 16) begin : g_src_w_bad
    $error("SRC_W out of range");
  end

  logic [SRC_W-1:0] src_s;
  logic             cap_s;
  logic             cap_prev_q;

  sync2 #(.WIDTH(SRC_W + 1)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .din   ({event_src, capture_pin}),
    .dout  ({src_s, cap_s})
  );

  // registers
  logic [DATA_W-1:0] ctrl_q;
  logic [SRC_W-1:0]  upsrc_q;
  logic [SRC_W-1:0]  dnsrc_q;
  logic [SRC_W-1:0]  src_prev_q;
  logic [CNT_W-1:0]  period_q;
  logic [CNT_W-1:0]  cmpa_q;
  logic [CNT_W-1:0]  cmpb_q;
  logic [CNT_W-1:0]  dtu_q;
  logic [ST_W-1:0]   stat_q;
  logic [ST_W-1:0]   mask_q;
  logic [CNT_W-1:0]  cnt_q;
  logic              down_q;
  logic              dirty_q;

  logic              wr_en;
  logic              rd_en;
  logic              addr_ok;
  logic [3:0]        be;

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign be      = pstrb;
  assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_UPSRC) ||
                   (paddr == ADDR_DNSRC) || (paddr == ADDR_PERIOD) ||
                   (paddr == ADDR_CMPA) || (paddr == ADDR_CMPB) ||
                   (paddr == ADDR_DTU) || (paddr == ADDR_STAT) ||
                   (paddr == ADDR_MASK) || (paddr == ADDR_CNT) ||
                   (paddr == ADDR_POSADJ);
  assign pslverr = psel && penable && !addr_ok;

  logic              run;
  logic              dt_en;
  logic              icap;
  logic [MODE_W-1:0] mode;
  logic              event_mode;
  count_kind_t       kind;

  assign run        = ctrl_q[CTRL_RUN_BIT];
  assign dt_en      = ctrl_q[CTRL_DTEN_BIT];
  assign icap       = ctrl_q[CTRL_ICAP_BIT];
  assign mode       = ctrl_q[CTRL_MODE_LSB +: MODE_W];
  assign event_mode = (|upsrc_q) || (|dnsrc_q);

  always_comb begin
    if (event_mode) begin
      kind = CNT_EVENT;
    end else if (icap) begin
      // only the top bit counts while capturing
      kind = mode[MODE_TOP_BIT] ? CNT_TRI : CNT_SAW; // RULE2 RULE3
    end else if (mode[MODE_TOP_BIT]) begin
      kind = CNT_TRI;
    end else begin
      kind = CNT_SAW;
    end
  end

  // mode changes while running are dropped and flagged
  logic mode_wr;
  logic mode_bad;
  assign mode_wr  = wr_en && (paddr == ADDR_CTRL) && be[2];
  assign mode_bad = mode_wr && run &&
                    (pwdata[CTRL_MODE_LSB +: MODE_W] != mode); // RULE1

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= ZERO_WORD;
    end else if (wr_en && paddr == ADDR_CTRL) begin
      if (be[0]) begin
        ctrl_q[7:0] <= pwdata[7:0];
      end
      if (be[2] && !mode_bad) begin
        ctrl_q[CTRL_MODE_LSB +: MODE_W] <=
          pwdata[CTRL_MODE_LSB +: MODE_W]; // RULE1
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upsrc_q  <= '0;
      dnsrc_q  <= '0;
      period_q <= '1;
      cmpa_q   <= '0;
      dtu_q    <= '0;
      mask_q   <= '0;
    end else if (wr_en) begin
      case (paddr)
        ADDR_UPSRC:  upsrc_q  <= pwdata[SRC_W-1:0];
        ADDR_DNSRC:  dnsrc_q  <= pwdata[SRC_W-1:0];
        ADDR_PERIOD: period_q <= pwdata[CNT_W-1:0];
        ADDR_CMPA:   cmpa_q   <= pwdata[CNT_W-1:0]; // RULE11
        ADDR_DTU:    dtu_q    <= pwdata[CNT_W-1:0];
        ADDR_MASK:   mask_q   <= pwdata[ST_W-1:0];
        default:     ;
      endcase
    end
  end

  // counter
  logic at_top;
  logic at_zero;
  logic [SRC_W-1:0] src_rise;
  assign at_top   = (cnt_q >= period_q);
  assign at_zero  = (cnt_q == '0);
  assign src_rise = src_s & ~src_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q      <= '0;
      down_q     <= 1'b0;
      src_prev_q <= '0;
    end else begin
      src_prev_q <= src_s;
      if (run) begin
        case (kind)
          CNT_SAW: begin
            cnt_q <= at_top ? '0 : cnt_q + 1'b1;
          end
          CNT_TRI: begin
            if (!down_q) begin
              cnt_q  <= at_top ? cnt_q - 1'b1 : cnt_q + 1'b1;
              down_q <= at_top;
            end else begin
              cnt_q  <= at_zero ? cnt_q + 1'b1 : cnt_q - 1'b1;
              down_q <= !at_zero;
            end
          end
          CNT_EVENT: begin
            if (|(src_rise & upsrc_q)) begin
              cnt_q <= cnt_q + 1'b1;
            end else if (|(src_rise & dnsrc_q)) begin
              cnt_q <= cnt_q - 1'b1;
            end
          end
          default: cnt_q <= '0;
        endcase
      end
    end
  end

  // dead-time computation; a sum past the period is the dead-time error
  logic [CNT_W:0]   neg_raw;
  logic             dt_err;
  logic [CNT_W-1:0] neg_cmp;
  logic [CNT_W-1:0] pos_cmp;
  logic             crest;

  assign neg_raw = {1'b0, cmpa_q} + {1'b0, dtu_q}; // RULE5
  assign dt_err  = dt_en && (neg_raw > {1'b0, period_q});

  always_comb begin
    if (dt_err) begin
      // shift both points back so the gap is kept
      neg_cmp = period_q; // RULE9
      pos_cmp = (period_q > dtu_q) ? period_q - dtu_q : '0; // RULE9
    end else begin
      neg_cmp = neg_raw[CNT_W-1:0];
      pos_cmp = cmpa_q; // RULE11
    end
  end

  assign crest = (kind == CNT_TRI) && run && at_top && !down_q;

  // any write to an input of the computation marks it dirty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dirty_q <= 1'b0;
    end else begin
      dirty_q <= wr_en && ((paddr == ADDR_CMPA) || (paddr == ADDR_DTU) ||
                 (paddr == ADDR_PERIOD) || (paddr == ADDR_CTRL));
    end
  end

  // software writes to compare b only land when dead time is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmpb_q <= '0;
    end else if (dt_en && (dirty_q || crest)) begin
      cmpb_q <= neg_cmp; // RULE7 RULE10 RULE13 RULE14
    end else if (!dt_en && wr_en && paddr == ADDR_CMPB) begin
      cmpb_q <= pwdata[CNT_W-1:0];
    end
  end

  // waveforms from internal compare points
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_out <= 1'b0;
      neg_out <= 1'b0;
    end else begin
      pos_out <= run && (cnt_q < pos_cmp); // RULE11
      neg_out <= run && dt_en && (cnt_q >= cmpb_q); // RULE10
    end
  end

  // status: set wins over clear
  logic [ST_W-1:0] ev;
  logic [ST_W-1:0] clr;
  always_comb begin
    ev = '0;
    ev[ST_OVF_BIT]   = run && (kind == CNT_SAW) && at_top;
    ev[ST_DTERR_BIT] = dt_err && dirty_q;
    ev[ST_CAPT_BIT]  = icap && cap_s && !cap_prev_q;
    ev[ST_ILLEG_BIT] = mode_bad || (event_mode && mode != MODE_INIT) ||
                       (wr_en && paddr == ADDR_CMPB && dt_en); // RULE4 RULE6
  end
  assign clr = (wr_en && paddr == ADDR_STAT) ? pwdata[ST_W-1:0] : '0;

  logic [CNT_W-1:0] capt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q     <= '0;
      cap_prev_q <= 1'b0;
      capt_q     <= '0;
    end else begin
      stat_q     <= (stat_q & ~clr) | ev;
      cap_prev_q <= cap_s;
      if (ev[ST_CAPT_BIT]) begin
        capt_q <= cnt_q;
      end
    end
  end

  assign irq = |(stat_q & mask_q);

  // read mux, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= ZERO_WORD;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_CTRL:   prdata <= ctrl_q;
        ADDR_UPSRC:  prdata <= {{(DATA_W-SRC_W){1'b0}}, upsrc_q};
        ADDR_DNSRC:  prdata <= {{(DATA_W-SRC_W){1'b0}}, dnsrc_q};
        ADDR_PERIOD: prdata <= {{(DATA_W-CNT_W){1'b0}}, period_q};
        ADDR_CMPA:   prdata <= {capt_q, cmpa_q};
        ADDR_CMPB:   prdata <= {{(DATA_W-CNT_W){1'b0}}, cmpb_q}; // RULE7
        ADDR_DTU:    prdata <= {{(DATA_W-CNT_W){1'b0}}, dtu_q};
        ADDR_STAT:   prdata <= {{(DATA_W-ST_W){1'b0}}, stat_q};
        ADDR_MASK:   prdata <= {{(DATA_W-ST_W){1'b0}}, mask_q};
        ADDR_CNT:    prdata <= {{(DATA_W-CNT_W){1'b0}}, cnt_q};
        ADDR_POSADJ: prdata <= {{(DATA_W-CNT_W){1'b0}}, pos_cmp};
        default:     prdata <= ZERO_WORD;
      endcase
    end
  end

  logic unused_rd;
  assign unused_rd = rd_en;
endmodule : pwm_mode_dead_time

// File: shared/pwm_dt_pkg.sv
// shared constants for the pwm mode and automatic dead-time block
package pwm_dt_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned CNT_W  = 16;

  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_UPSRC  = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_DNSRC  = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_PERIOD = 12'h00C;
  localparam logic [ADDR_W-1:0] ADDR_CMPA   = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_CMPB   = 12'h014;
  localparam logic [ADDR_W-1:0] ADDR_DTU    = 12'h018;
  localparam logic [ADDR_W-1:0] ADDR_STAT   = 12'h01C;
  localparam logic [ADDR_W-1:0] ADDR_MASK   = 12'h020;
  localparam logic [ADDR_W-1:0] ADDR_CNT    = 12'h024;
  localparam logic [ADDR_W-1:0] ADDR_POSADJ = 12'h028;

  // control word fields
  localparam int unsigned CTRL_RUN_BIT  = 0;
  localparam int unsigned CTRL_DTEN_BIT = 1;
  localparam int unsigned CTRL_ICAP_BIT = 2;
  localparam int unsigned CTRL_MODE_LSB = 16;
  localparam int unsigned MODE_W        = 3;
  localparam int unsigned MODE_TOP_BIT  = 2;

  localparam logic [MODE_W-1:0] MODE_INIT     = 3'h0;
  localparam logic [MODE_W-1:0] MODE_SAW      = 3'h0;
  localparam logic [MODE_W-1:0] MODE_SAW_ONE  = 3'h1;

  // status / mask bits
  localparam int unsigned ST_W         = 4;
  localparam int unsigned ST_OVF_BIT   = 0;
  localparam int unsigned ST_DTERR_BIT = 1;
  localparam int unsigned ST_CAPT_BIT  = 2;
  localparam int unsigned ST_ILLEG_BIT = 3;

  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {CNT_SAW, CNT_TRI, CNT_EVENT} count_kind_t;
endpackage : pwm_dt_pkg

// File: src/sync2.sv
// two flip-flop synchroniser for a pin level
`timescale 1ns/100ps
module sync2 #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // level in and out
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : sync2

// File: tb/pwm_mode_dead_time_props.sv
// port assertions for the pwm mode and dead-time block
`timescale 1ns/100ps
module pwm_mode_dead_time_props
  import pwm_dt_pkg::*;
#(
  parameter int unsigned SRC_W = 4
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [SRC_W-1:0]  event_src,
  input wire logic              capture_pin,
  input wire logic              pos_out,
  input wire logic              neg_out,
  input wire logic              irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [15:0] cmpa_q, dtu_q, per_q;
  logic        dten_q;
  logic [1:0]  gap_q;
  logic [16:0] sum;
  logic        err, rd_ok, acc;
  assign acc = psel && penable;
  assign sum = {1'b0, cmpa_q} + {1'b0, dtu_q};
  assign err = sum > {1'b0, per_q};
  // two idle edges let the recomputed compare b reach the read latch
  assign rd_ok = acc && !pwrite && gap_q == 2'd2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmpa_q <= '0;
      dtu_q  <= '0;
      per_q  <= 16'hffff;
      dten_q <= 1'b0;
      gap_q  <= '0;
    end else begin
      if (acc && pwrite) gap_q <= '0;
      else if (gap_q != 2'd2) gap_q <= gap_q + 2'd1;
      if (acc && pwrite && paddr == ADDR_CMPA) cmpa_q <= pwdata[15:0];
      if (acc && pwrite && paddr == ADDR_DTU) dtu_q <= pwdata[15:0];
      if (acc && pwrite && paddr == ADDR_PERIOD) per_q <= pwdata[15:0];
      if (acc && pwrite && paddr == ADDR_CTRL && pstrb[0])
        dten_q <= pwdata[CTRL_DTEN_BIT];
    end
  end
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_slverr_map: assert property (acc && paddr > ADDR_POSADJ |-> pslverr)
    else $error("unmapped access not refused");
  a_slverr_idle: assert property (!acc |-> !pslverr)
    else $error("pslverr outside access");
  a_cmpb_auto: assert property (
    rd_ok && dten_q && paddr == ADDR_CMPB && !err
    |-> prdata[15:0] == sum[15:0]) else $error("compare b not auto value");
  a_neg_clamp: assert property (
    rd_ok && dten_q && paddr == ADDR_CMPB && err
    |-> prdata[15:0] == per_q) else $error("negative point not adjusted");
  a_pos_adjust: assert property (
    rd_ok && dten_q && paddr == ADDR_POSADJ && err
    |-> prdata[15:0] == per_q - dtu_q) else $error("positive point wrong");
  a_cmpa_kept: assert property (
    rd_ok && paddr == ADDR_CMPA |-> prdata[15:0] == cmpa_q)
    else $error("compare a modified");
  a_irq_masked: assert property (
    acc && pwrite && paddr == ADDR_MASK && pwdata[3:0] == 4'h0 |=> !irq)
    else $error("irq high with all masked");
  a_reset_quiet: assert property (
    $rose(presetn) |-> !irq && !pos_out && !neg_out)
    else $error("outputs active after reset");
  cover property (rd_ok && dten_q && paddr == ADDR_CMPB && err);
  cover property (rd_ok && dten_q && paddr == ADDR_CMPB && !err);
  cover property (irq);
endmodule : pwm_mode_dead_time_props

// File: tb/pwm_mode_dead_time_tb.sv
// self-checking bench for the pwm mode and dead-time block
`timescale 1ns/100ps
module pwm_mode_dead_time_tb
  import pwm_dt_pkg::*;
;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rv, rnd;
  logic [3:0]        pstrb, event_src;
  logic              capture_pin, pos_out, neg_out, irq, slv;
  logic [15:0]       p, c, d, cnt0;
  int                n_errors, total_checks;
  int                np, nn, nb, ne;
  pwm_mode_dead_time i_pwm_mode_dead_time (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .event_src(event_src), .capture_pin(capture_pin),
    .pos_out(pos_out), .neg_out(neg_out), .irq(irq));
  always #25 pclk = ~pclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [15:0] neg_exp(input logic [15:0] a, t, per);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, t};
    return (s > {1'b0, per}) ? per : s[15:0];
  endfunction : neg_exp
  task automatic check(input string nm, input logic [DATA_W-1:0] s, e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  // an idle edge before each setup keeps every signal to one change a step
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    // a slave that never answers is left to the watchdog
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // output highs over one whole count cycle, sampled mid-cycle
  task automatic count_outs(input int n, output int hp, hn, hb);
    hp = 0;
    hn = 0;
    hb = 0;
    @(posedge pclk);
    repeat (n) begin
      @(negedge pclk);
      hp += (pos_out === 1'b1);
      hn += (neg_out === 1'b1);
      hb += (pos_out === 1'b1 && neg_out === 1'b1);
    end
  endtask : count_outs
  task automatic complete_run;
    if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    #(50 * 8000);
    n_errors++;
    complete_run();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, capture_pin} = '0;
    {paddr, pwdata, event_src} = '0;
    pstrb = 4'hf;
    rnd = 32'h0123_e4e4;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check("outs", {pos_out, neg_out, irq}, '0);
    apb(1'b0, ADDR_PERIOD, '0);
    check("period", rv, 32'h0000_ffff);
    apb(1'b1, ADDR_CTRL, 32'h0000_0002);
    for (int i = 0; i < 9; i++) begin
      rnd = lfsr(rnd);
      p = rnd[15:0] | 16'h8000;
      c = rnd[29:16] & 16'h3fff;
      d = 16'(lfsr(rnd)) & 16'h0fff;
      // last pass drives the dead time past the period end
      if (i == 8) {p, c, d} = {16'h1000, 16'h0ff8, 16'h0020};
      apb(1'b1, ADDR_PERIOD, {16'h0000, p});
      apb(1'b1, ADDR_CMPA, {16'h0000, c});
      apb(1'b1, ADDR_DTU, {16'h0000, d});
      apb(1'b0, ADDR_CMPB, '0);
      check("cmpb", rv[15:0], neg_exp(c, d, p));
      apb(1'b0, ADDR_CMPA, '0);
      check("cmpa", rv[15:0], c);
    end
    apb(1'b0, ADDR_POSADJ, '0);
    check("posadj", rv[15:0], 16'h0fe0);
    apb(1'b1, ADDR_CMPB, 32'h0000_1234);
    apb(1'b0, ADDR_CMPB, '0);
    check("cmpb_kept", rv[15:0], 16'h1000);
    apb(1'b0, ADDR_STAT, '0);
    check("stat", rv[3:0] & 4'ha, 4'ha);
    apb(1'b1, ADDR_MASK, 32'h0000_0002);
    @(negedge pclk);
    check("irq_on", irq, 1'b1);
    apb(1'b1, ADDR_STAT, 32'h0000_000a);
    @(negedge pclk);
    check("irq_off", irq, 1'b0);
    apb(1'b1, ADDR_MASK, '0);
    apb(1'b0, 12'h0fc, '0);
    check("slverr", slv, 1'b1);
    check("rd_unmapped", rv, ZERO_WORD);
    // short random period so whole count cycles fit in a window
    rnd = lfsr(rnd);
    p = 16'h0010 + rnd[3:0];
    c = 16'h0002 + rnd[6:4];
    d = 16'h0001 + rnd[9:8];
    apb(1'b1, ADDR_PERIOD, {16'h0000, p});
    apb(1'b1, ADDR_CMPA, {16'h0000, c});
    apb(1'b1, ADDR_DTU, {16'h0000, d});
    apb(1'b1, ADDR_CTRL, 32'h0000_0003);
    count_outs(p + 1, np, nn, nb);
    check("saw_pos", np, c);
    check("saw_neg", nn, p + 1 - c - d);
    check("saw_gap", nb, 0);
    // mode only changes with the counter stopped
    apb(1'b1, ADDR_CTRL, 32'h0000_0002);
    apb(1'b1, ADDR_CTRL, 32'h0004_0003);
    count_outs(2 * p, np, nn, nb);
    check("tri_pos", np, 2 * c - 1);
    check("tri_neg", nn, 2 * (p - c - d) + 1);
    apb(1'b0, ADDR_CMPB, '0);
    check("tri_cmpb", rv[15:0], neg_exp(c, d, p));
    // a mode change while running is dropped
    apb(1'b1, ADDR_CTRL, 32'h0000_0003);
    apb(1'b0, ADDR_CTRL, '0);
    check("mode_kept", rv, 32'h0004_0003);
    apb(1'b1, ADDR_CTRL, 32'h0004_0002);
    apb(1'b1, ADDR_CTRL, 32'h0003_0007);
    count_outs(p + 1, np, nn, nb);
    check("icap_saw", np, c);
    @(posedge pclk);
    capture_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    capture_pin <= 1'b0;
    apb(1'b0, ADDR_STAT, '0);
    check("capt", rv[ST_CAPT_BIT], 1'b1);
    apb(1'b1, ADDR_CTRL, 32'h0003_0006);
    apb(1'b1, ADDR_CTRL, 32'h0007_0007);
    count_outs(2 * p, np, nn, nb);
    check("icap_tri", np, 2 * c - 1);
    // event counting keeps the mode field at its initial value
    apb(1'b1, ADDR_CTRL, 32'h0007_0006);
    apb(1'b1, ADDR_CTRL, 32'h0000_0002);
    apb(1'b0, ADDR_CNT, '0);
    cnt0 = rv[15:0];
    apb(1'b1, ADDR_UPSRC, 32'h0000_0001);
    apb(1'b1, ADDR_CTRL, 32'h0000_0003);
    ne = 1 + rnd[12:10];
    repeat (ne) begin
      @(posedge pclk);
      event_src <= 4'h1;
      repeat (3) @(posedge pclk);
      event_src <= 4'h0;
      repeat (2) @(posedge pclk);
    end
    apb(1'b1, ADDR_CTRL, 32'h0000_0002);
    apb(1'b0, ADDR_CNT, '0);
    check("events", rv[15:0], cnt0 + 16'(ne));
    apb(1'b1, ADDR_UPSRC, '0);
    complete_run();
  end
endmodule : pwm_mode_dead_time_tb
bind pwm_mode_dead_time pwm_mode_dead_time_props #(.SRC_W(SRC_W)) i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .event_src(event_src), .capture_pin(capture_pin), .pos_out(pos_out),
  .neg_out(neg_out), .irq(irq));
